// >>> bench/mmr_cpu_model.sv
// Purpose: Random fetch, data and DMA requester for the memory map
// Assumes: Requests change just after the rising edge
// Notes: Bit accesses are direct DATA reads
`timescale 1ns/10ps
module mmr_cpu_model (
   // Clock and control
   input wire logic ref_clk,
   input wire logic en,
   // Requests
   output logic fetch_req,
   output logic [15:0] fetch_addr,
   output logic data_req,
   output logic data_we,
   output logic data_indirect,
   output logic data_bit,
   output mmr_pkg::mmr_space_t data_space,
   output logic [15:0] data_addr,
   output logic dma_req,
   output logic dma_we,
   output logic [15:0] dma_addr
);
   import mmr_pkg::*;
   logic [31:0] r;
   logic [31:0] a;
   logic b;
   initial begin
      {fetch_req, fetch_addr, data_req, data_we, data_indirect} = '0;
      {data_bit, data_addr, dma_req, dma_we, dma_addr} = '0;
      data_space = MMR_S_CODE;
   end
   always @(posedge ref_clk) begin
      r = $urandom;
      a = $urandom;
      b = r[7:5] == 3'h0;
      fetch_req <= en && r[1:0] != 2'h0;
      fetch_addr <= a[15:0];
      data_req <= en && r[2];
      data_we <= r[3] && !b;
      data_indirect <= r[4] && !b;
      data_bit <= b;
      data_space <= b ? MMR_S_DATA : mmr_space_t'(r[9:8]);
      // Narrow spaces get 8-bit addresses, special space upper half
      data_addr <= (!r[8] && !b) ? a[31:16] :
         {8'h0, (r[9] && !b) | a[23], a[22:16]};
      dma_req <= en && r[10];
      dma_we <= r[11];
      dma_addr <= r[12] ? {8'hdf, r[23:16]} : r[31:16];
   end
endmodule : mmr_cpu_model

// >>> bench/mmr_top_test.sv
// Purpose: Self-checking bench for the memory map and reset block
// Assumes: Partner model drives fetch, data and DMA ports
// Notes: Reference model compares every result at the falling edge
`timescale 1ns/10ps
module mmr_top_test;
   import mmr_pkg::*;
   logic ref_clk, rst_n, por, wdt_timeout, unified_map_select_bit;
   logic wdt_enable_req, en, mon_on, eg;
   logic [NUM_IRQ-1:0] irq_src, irq_pend_r, p_irq;
   logic fetch_req, data_req, data_we, data_indirect, data_bit;
   logic dma_req, dma_we, core_rst_r, wdt_en_r, unif_r;
   logic fetch_gnt_r, data_gnt_r, data_err_r, dma_gnt_r;
   logic [15:0] fetch_addr, data_addr, dma_addr, pc_r, p_fa;
   logic [15:0] fetch_phys_r, data_phys_r, dma_phys_r;
   mmr_space_t data_space;
   mmr_tgt_t fetch_tgt_r, data_tgt_r, dma_tgt_r;
   logic [NUM_GPIO-1:0] gpio_oe_r, gpio_pu_r;
   logic [2:0] data_bitpos_r, xbusy_cnt_r, cnt, p_bp;
   logic p_core, p_dma, p_freq, p_xd, p_dreq, p_err, p_dbit;
   logic [17:0] p_dx, p_fx, p_dd;
   int miscompares, checks;

   mmr_top #(.FLASH_KB(64)) dut (.ref_clk, .rst_n, .por, .wdt_timeout,
      .unified_map_select_bit, .wdt_enable_req, .irq_src, .fetch_req,
      .fetch_addr, .data_req, .data_we, .data_indirect, .data_bit,
      .data_space, .data_addr, .dma_req, .dma_we, .dma_addr, .core_rst_r,
      .pc_r, .wdt_en_r, .gpio_oe_r, .gpio_pu_r, .irq_pend_r, .unif_r,
      .fetch_gnt_r, .fetch_tgt_r, .fetch_phys_r, .data_gnt_r, .data_tgt_r,
      .data_phys_r, .data_bitpos_r, .data_err_r, .dma_gnt_r, .dma_tgt_r,
      .dma_phys_r, .xbusy_cnt_r);
   mmr_cpu_model cpu (.ref_clk, .en, .fetch_req, .fetch_addr, .data_req,
      .data_we, .data_indirect, .data_bit, .data_space, .data_addr,
      .dma_req, .dma_we, .dma_addr);

   // ----------------------------------------
   // Reference model
   // ----------------------------------------
   function automatic logic [17:0] xmap(input logic [15:0] a);
      if (a >= SRAM_LO) return {MMR_T_SRAM, 16'(a - SRAM_LO)};
      if (a >= REG_LO) return {MMR_T_REG, 16'(a - REG_LO)};
      if (a <= FL_HI_BIG) return {MMR_T_FLASH, a};
      return {MMR_T_NONE, 16'h0};
   endfunction : xmap

   function automatic logic [17:0] dmap(input logic [15:0] a);
      if (data_bit) return a[7] ? {MMR_T_REG, 9'h0, a[6:3], 3'h0} :
         {MMR_T_SRAM, 16'(IDATA_BASE - SRAM_LO + 16'h20 + a[6:3])};
      case (data_space)
         MMR_S_CODE: return unified_map_select_bit ? xmap(a) :
            {MMR_T_FLASH, a};
         MMR_S_DATA: return {MMR_T_SRAM, 16'(IDATA_BASE - SRAM_LO + a[7:0])};
         MMR_S_SFR: return {MMR_T_REG, 9'h0, a[6:0]};
         default: return xmap(a);
      endcase
   endfunction : dmap

   task cmp(input string n, input logic [20:0] e, input logic [20:0] g);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : cmp

   task cmp_map(input string n, input logic [17:0] e, input logic [17:0] g);
      if (e[17:16] == MMR_T_NONE) cmp(n, e[17:16], g[17:16]);
      else cmp(n, e, g);
   endtask : cmp_map

   always @(negedge ref_clk) begin
      if (mon_on && !p_core) begin
         cmp("dma_gnt", p_dma, dma_gnt_r);
         if (p_dma) cmp_map("dma_map", p_dx, {dma_tgt_r, dma_phys_r});
         eg = p_freq && !p_xd && cnt == 3'h0;
         cmp("fetch_gnt", eg, fetch_gnt_r);
         if (eg) cmp_map("fetch", p_fx, {fetch_tgt_r, fetch_phys_r});
         else cmp("fetch_none", MMR_T_NONE, fetch_tgt_r);
         if (eg) cmp("pc", p_fa + 16'h1, pc_r);
         cnt = p_xd ? 3'(EXTERNAL_DATA_SPACE_CYC_MIN - 1) : cnt - {2'h0, cnt != 3'h0};
         cmp("xbusy", cnt, xbusy_cnt_r);
         cmp("irq", p_irq, irq_pend_r);
         cmp("data_gnt", p_dreq && !p_err, data_gnt_r);
         if (p_dreq) begin
            cmp("data_err", p_err, data_err_r);
            if (p_err) cmp("data_none", MMR_T_NONE, data_tgt_r);
            else cmp_map("data", p_dd, {data_tgt_r, data_phys_r});
            if (p_dbit) cmp("bitpos", p_bp, data_bitpos_r);
         end
      end else cnt = 3'h0;
      p_core = core_rst_r;
      p_dma = dma_req;
      p_dx = xmap(dma_addr);
      p_freq = fetch_req;
      p_fa = fetch_addr;
      p_fx = unified_map_select_bit ? xmap(fetch_addr) :
         {MMR_T_FLASH, fetch_addr};
      p_xd = data_req && data_space == MMR_S_EXTERNAL_DATA_SPACE;
      p_dreq = data_req;
      // Program writes and direct upper data accesses are refused
      p_err = (data_we && data_space == MMR_S_CODE) || (!data_bit &&
         data_space == MMR_S_DATA && !data_indirect && data_addr[7]);
      p_dd = dmap(data_addr);
      p_dbit = data_bit;
      p_bp = data_addr[2:0];
      p_irq = irq_src;
   end

   // ----------------------------------------
   // Sequences
   // ----------------------------------------
   task give_verdict;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : give_verdict

   task settle;
      int n;
      n = 0;
      @(negedge ref_clk);
      while (core_rst_r !== 1'b0 && n < 20) begin
         n++;
         @(negedge ref_clk);
      end
      cmp("rst_hold", 1'b1, n >= 3);
      cmp("rst_done", 1'b0, core_rst_r);
      cmp("pc_rst", PC_RESET, pc_r);
      cmp("wdt_rst", WDT_EN_RESET, wdt_en_r);
      cmp("gpio_oe", '0, gpio_oe_r);
      cmp("gpio_pu", {NUM_GPIO{1'b1}}, gpio_pu_r);
      cmp("unif", unified_map_select_bit, unif_r);
      @(posedge ref_clk);
   endtask : settle

   task do_reset(input int s);
      wdt_enable_req <= 1'b1;
      unified_map_select_bit <= 1'b1;
      @(posedge ref_clk);
      wdt_enable_req <= 1'b0;
      @(negedge ref_clk);
      cmp("wdt_set", 1'b1, wdt_en_r);
      @(posedge ref_clk);
      rst_n <= s != 0;
      por <= s == 1;
      wdt_timeout <= s == 2;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      cmp("unif_rst", UNIF_RESET, unif_r);
      @(posedge ref_clk);
      {rst_n, por, wdt_timeout} <= 3'h4;
      settle();
   endtask : do_reset

   task traffic(input logic u);
      unified_map_select_bit <= u;
      repeat (3) @(posedge ref_clk);
      en <= 1'b1;
      repeat (400) @(posedge ref_clk);
      en <= 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask : traffic

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) irq_src <= NUM_IRQ'($urandom);

   initial begin
      #200000;
      miscompares++;
      give_verdict();
   end

   initial begin
      void'($urandom(32'hcabe72eb));
      {rst_n, por, wdt_timeout, unified_map_select_bit} = 4'h0;
      {wdt_enable_req, en, mon_on} = '0;
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      settle();
      for (int s = 0; s < 3; s++) do_reset(s);
      mon_on = 1'b1;
      traffic(1'b0);
      traffic(1'b1);
      give_verdict();
   end
endmodule : mmr_top_test

// >>> hw/mmr_decode.sv
// Purpose: Combinational map of one logical access to a physical target
// Assumes: Flash size is a parameter in KB
// Notes: Unmapped addresses return target none
`timescale 1ns/10ps
module mmr_decode #(parameter int FLASH_KB = 64) (
   // Request
   input wire mmr_pkg::mmr_space_t space,
   input wire logic [15:0] addr,
   input wire logic indirect,
   input wire logic unified_map_select_bit,
   // Result
   output mmr_pkg::mmr_tgt_t tgt,
   output logic [15:0] phys,
   output logic illegal
);
   import mmr_pkg::*;
   logic [15:0] fl_hi;
   assign fl_hi = (FLASH_KB > 32) ? FL_HI_BIG : FL_HI_32K;
   always_comb begin
      tgt = MMR_T_NONE;
      phys = 16'h0000;
      illegal = 1'b0;
      unique case (space)
         MMR_S_CODE: begin
            if (!unified_map_select_bit) begin
               tgt = MMR_T_FLASH;
               phys = addr;
            end else if (addr >= SRAM_LO) begin
               tgt = MMR_T_SRAM;
               phys = addr - SRAM_LO;
            end else if (addr >= REG_LO) begin
               tgt = MMR_T_REG;
               phys = addr - REG_LO;
            end else if (addr <= fl_hi) begin
               tgt = MMR_T_FLASH;
               phys = addr;
            end
         end
         MMR_S_EXTERNAL_DATA_SPACE: begin
            if (addr >= SRAM_LO) begin
               tgt = MMR_T_SRAM;
               phys = addr - SRAM_LO;
            end else if (addr >= REG_LO) begin
               tgt = MMR_T_REG;
               phys = addr - REG_LO;
            end else if (addr <= fl_hi) begin
               tgt = MMR_T_FLASH;
               phys = addr;
            end
         end
         MMR_S_DATA: begin
            // Upper half reachable only indirectly
            tgt = MMR_T_SRAM;
            phys = IDATA_BASE - SRAM_LO + {8'h00, addr[7:0]};
            illegal = (addr[7:0] > DIRECT_HI) && !indirect;
            if (illegal) tgt = MMR_T_NONE;
         end
         MMR_S_SFR: begin
            tgt = MMR_T_REG;
            phys = {9'h000, addr[6:0]};
            illegal = addr[7:0] < SFR_BASE;
            if (illegal) tgt = MMR_T_NONE;
         end
      endcase
   end
endmodule : mmr_decode

// >>> hw/mmr_pkg.sv
// Purpose: Constants and types for the memory map and reset block
// Assumes: 100 MHz ref_clk, one clock domain
// Notes: Address windows of the external and program spaces
package mmr_pkg;
   localparam int ADDR_W = 16;
   localparam int SRAM_AW = 13;
   localparam int REG_AW = 7;
   localparam int NUM_GPIO = 21;
   localparam int NUM_IRQ = 18;
   localparam int NUM_RST_SRC = 3;
   localparam int STD_CLK_PER_CYC = 12;
   localparam int CLK_PER_CYC = 1;
   localparam int EXTERNAL_DATA_SPACE_CYC_MIN = 4;
   localparam int EXTERNAL_DATA_SPACE_CYC_MAX = 5;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [15:0] SRAM_LO = 16'he000;
   localparam logic [15:0] REG_LO = 16'hdf80;
   localparam logic [15:0] REG_HI = 16'hdfff;
   localparam logic [15:0] FL_HI_BIG = 16'hdeff;
   localparam logic [15:0] FL_HI_32K = 16'h7fff;
   localparam logic [15:0] IDATA_BASE = 16'hff00;
   localparam logic [7:0] DIRECT_HI = 8'h7f;
   localparam logic [7:0] SFR_BASE = 8'h80;
   localparam logic [2:0] BIT_ADDR_MASK = 3'h7;
   localparam logic UNIF_RESET = 1'b0;
   localparam logic WDT_EN_RESET = 1'b0;
   localparam logic [1:0] RST_HOLD = 2'h3;
   typedef enum logic [1:0] {MMR_T_NONE, MMR_T_FLASH, MMR_T_SRAM,
      MMR_T_REG} mmr_tgt_t;
   typedef enum logic [1:0] {MMR_S_CODE, MMR_S_DATA, MMR_S_EXTERNAL_DATA_SPACE,
      MMR_S_SFR} mmr_space_t;
endpackage : mmr_pkg

// >>> hw/mmr_reset.sv
// Purpose: Combine reset sources into one held core reset
// Assumes: Sources are synchronous, active high
// Notes: Core reset holds a few cycles after last source drops
`timescale 1ns/10ps
module mmr_reset (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Sources
   input wire logic por,
   input wire logic wdt_timeout,
   // Result
   output logic core_rst
);
   import mmr_pkg::*;
   logic [1:0] cnt_r, cnt_nxt;
   logic any_src;
   assign any_src = !rst_n || por || wdt_timeout;
   always_comb begin
      cnt_nxt = cnt_r;
      if (any_src) cnt_nxt = RST_HOLD;
      else if (cnt_r != 2'h0) cnt_nxt = cnt_r - 2'h1;
   end
   always_ff @(posedge ref_clk) begin
      cnt_r <= cnt_nxt;
   end
   assign core_rst = any_src || (cnt_r != 2'h0);
endmodule : mmr_reset

// >>> hw/mmr_top.sv
// Purpose: Memory map decode and reset initialisation for the CPU core
// Assumes: Single clock, synchronous requests from fetch, data and DMA
// Notes: All outputs registered; one result per cycle per port
//
// What this block does
// - One clock per instruction cycle
// - Interrupt unit accepts eighteen sources
// - Reset from pin, power-on or watchdog
// - After reset all I/O inputs with pull-up
// - Program counter starts at zero after reset
// - Peripheral registers return to reset values
// - Watchdog disabled after any reset
// - Program space read-only, up to 64 KB
// - Data space 256 bytes, upper indirect only
// - External data 64 KB, four-cycle access
// - Fetch never overlaps external data access
// - 128-byte register space, directly addressable
// - Bit addressing for registers at multiples of eight
// - Registers and program mapped into external data
// - Three physical targets: flash, SRAM, registers
// - Standard program mapping after reset
// - Unified bit selects program space layout
// - External data E000-FFFF maps to SRAM
// - External data DF80-DFFF maps to registers
// - Flash below DF00, or 7FFF on small parts
// - Data space is top 256 SRAM bytes
`timescale 1ns/10ps
module mmr_top #(parameter int FLASH_KB = 64) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Reset sources
   input wire logic por,
   input wire logic wdt_timeout,
   // Control
   input wire logic unified_map_select_bit,
   input wire logic wdt_enable_req,
   input wire logic [mmr_pkg::NUM_IRQ-1:0] irq_src,
   // Fetch port
   input wire logic fetch_req,
   input wire logic [15:0] fetch_addr,
   // Data port
   input wire logic data_req,
   input wire logic data_we,
   input wire logic data_indirect,
   input wire logic data_bit,
   input wire mmr_pkg::mmr_space_t data_space,
   input wire logic [15:0] data_addr,
   // DMA port
   input wire logic dma_req,
   input wire logic dma_we,
   input wire logic [15:0] dma_addr,
   // Outputs
   output logic core_rst_r,
   output logic [15:0] pc_r,
   output logic wdt_en_r,
   output logic [mmr_pkg::NUM_GPIO-1:0] gpio_oe_r,
   output logic [mmr_pkg::NUM_GPIO-1:0] gpio_pu_r,
   output logic [mmr_pkg::NUM_IRQ-1:0] irq_pend_r,
   output logic unif_r,
   output logic fetch_gnt_r,
   output mmr_pkg::mmr_tgt_t fetch_tgt_r,
   output logic [15:0] fetch_phys_r,
   output logic data_gnt_r,
   output mmr_pkg::mmr_tgt_t data_tgt_r,
   output logic [15:0] data_phys_r,
   output logic [2:0] data_bitpos_r,
   output logic data_err_r,
   output logic dma_gnt_r,
   output mmr_pkg::mmr_tgt_t dma_tgt_r,
   output logic [15:0] dma_phys_r,
   output logic [2:0] xbusy_cnt_r
);
   import mmr_pkg::*;

   // ----------------------------------------
   // Reset combine
   // ----------------------------------------
   logic core_rst;
   mmr_reset u_rst (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .por(por),
      .wdt_timeout(wdt_timeout),
      .core_rst(core_rst)
   );

   // ----------------------------------------
   // Decoders
   // ----------------------------------------
   mmr_tgt_t f_tgt, d_tgt, x_tgt;
   logic [15:0] f_phys, d_phys, x_phys;
   logic d_ill;
   logic [15:0] d_addr_eff;
   mmr_space_t d_space_eff;

   // Bit address: upper half picks register at multiple of eight
   always_comb begin
      d_addr_eff = data_addr;
      d_space_eff = data_space;
      if (data_bit) begin
         if (data_addr[7]) begin
            d_space_eff = MMR_S_SFR;
            d_addr_eff = {8'h00, data_addr[7:3], 3'h0};
         end else begin
            d_space_eff = MMR_S_DATA;
            d_addr_eff = {8'h00, 4'h2, data_addr[6:3]};
         end
      end
   end

   mmr_decode #(.FLASH_KB(FLASH_KB)) u_fdec (
      .space(MMR_S_CODE),
      .addr(fetch_addr),
      .indirect(1'b0),
      .unified_map_select_bit(unif_r),
      .tgt(f_tgt),
      .phys(f_phys),
      .illegal()
   );
   mmr_decode #(.FLASH_KB(FLASH_KB)) u_ddec (
      .space(d_space_eff),
      .addr(d_addr_eff),
      .indirect(data_indirect),
      .unified_map_select_bit(unif_r),
      .tgt(d_tgt),
      .phys(d_phys),
      .illegal(d_ill)
   );
   mmr_decode #(.FLASH_KB(FLASH_KB)) u_xdec (
      .space(MMR_S_EXTERNAL_DATA_SPACE),
      .addr(dma_addr),
      .indirect(1'b1),
      .unified_map_select_bit(unif_r),
      .tgt(x_tgt),
      .phys(x_phys),
      .illegal()
   );

   // ----------------------------------------
   // Arbitration and state
   // ----------------------------------------
   logic x_acc, code_wr, fetch_ok;
   logic [2:0] xbusy_nxt;
   logic [15:0] pc_nxt;
   logic wdt_nxt, unif_nxt;
   logic [NUM_IRQ-1:0] irq_nxt;

   assign x_acc = data_req && (data_space == MMR_S_EXTERNAL_DATA_SPACE) && !data_bit;
   // Writes to program space are dropped
   assign code_wr = data_req && data_we && (data_space == MMR_S_CODE);
   // Fetch stalls while external data access owns the bus
   assign fetch_ok = fetch_req && !x_acc && (xbusy_cnt_r == 3'h0);

   always_comb begin
      xbusy_nxt = xbusy_cnt_r;
      // Each new external access restarts the bus hold
      if (x_acc)
         xbusy_nxt = 3'(EXTERNAL_DATA_SPACE_CYC_MIN - 1);
      else if (xbusy_cnt_r != 3'h0)
         xbusy_nxt = xbusy_cnt_r - 3'h1;
      pc_nxt = fetch_ok ? fetch_addr + 16'(CLK_PER_CYC) : pc_r;
      wdt_nxt = wdt_en_r | wdt_enable_req;
      unif_nxt = unified_map_select_bit;
      irq_nxt = irq_src;
   end

   always_ff @(posedge ref_clk) begin
      core_rst_r <= core_rst;
      if (core_rst) begin
         pc_r <= PC_RESET;
         wdt_en_r <= WDT_EN_RESET;
         gpio_oe_r <= '0;
         gpio_pu_r <= '1;
         irq_pend_r <= '0;
         unif_r <= UNIF_RESET;
         xbusy_cnt_r <= 3'h0;
         fetch_gnt_r <= 1'b0;
         fetch_tgt_r <= MMR_T_NONE;
         fetch_phys_r <= 16'h0000;
         data_gnt_r <= 1'b0;
         data_tgt_r <= MMR_T_NONE;
         data_phys_r <= 16'h0000;
         data_bitpos_r <= 3'h0;
         data_err_r <= 1'b0;
         dma_gnt_r <= 1'b0;
         dma_tgt_r <= MMR_T_NONE;
         dma_phys_r <= 16'h0000;
      end else begin
         pc_r <= pc_nxt;
         wdt_en_r <= wdt_nxt;
         gpio_oe_r <= gpio_oe_r;
         gpio_pu_r <= gpio_pu_r;
         irq_pend_r <= irq_nxt;
         unif_r <= unif_nxt;
         xbusy_cnt_r <= xbusy_nxt;
         fetch_gnt_r <= fetch_ok;
         fetch_tgt_r <= fetch_ok ? f_tgt : MMR_T_NONE;
         fetch_phys_r <= f_phys;
         data_gnt_r <= data_req && !code_wr && !d_ill;
         data_tgt_r <= (data_req && !code_wr) ? d_tgt : MMR_T_NONE;
         data_phys_r <= d_phys;
         data_bitpos_r <= data_addr[2:0] & BIT_ADDR_MASK;
         data_err_r <= data_req && (code_wr || d_ill);
         dma_gnt_r <= dma_req;
         dma_tgt_r <= dma_req ? x_tgt : MMR_T_NONE;
         dma_phys_r <= x_phys;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   chk_pc_reset_zero: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      $fell(core_rst) |-> pc_r == PC_RESET)
      else $error("pc not zero after reset");
   chk_wdt_off_reset: assert property (
      @(posedge ref_clk)
      core_rst |=> !wdt_en_r)
      else $error("watchdog enabled in reset");
   chk_rst_sources: assert property (
      @(posedge ref_clk)
      (por || wdt_timeout || !rst_n) |=> core_rst_r)
      else $error("reset source ignored");
   chk_gpio_input_pu: assert property (
      @(posedge ref_clk)
      core_rst |=> (gpio_oe_r == '0 && gpio_pu_r == '1))
      else $error("gpio not input pull-up");
   chk_std_map_reset: assert property (
      @(posedge ref_clk)
      core_rst |=> !unif_r)
      else $error("unified map after reset");
   chk_external_data_space_sram: assert property (
      @(posedge ref_clk) disable iff (core_rst)
      (dma_req && dma_addr >= SRAM_LO) |=> dma_tgt_r == MMR_T_SRAM)
      else $error("sram window miss");
   chk_external_data_space_regs: assert property (
      @(posedge ref_clk) disable iff (core_rst)
      (dma_req && dma_addr >= REG_LO && dma_addr <= REG_HI)
      |=> dma_tgt_r == MMR_T_REG)
      else $error("register window miss");
   chk_no_fetch_xacc: assert property (
      @(posedge ref_clk) disable iff (core_rst)
      x_acc |=> !fetch_gnt_r ##1 !fetch_gnt_r[*3])
      else $error("fetch overlaps external access");
   chk_std_code_flash: assert property (
      @(posedge ref_clk) disable iff (core_rst)
      (fetch_ok && !unif_r) |=> fetch_tgt_r == MMR_T_FLASH)
      else $error("standard map not flash");

   // ----------------------------------------
   // Map and state checks
   // ----------------------------------------
   chk_pc_hold_reset: assert property (
      @(posedge ref_clk)
      core_rst |=> pc_r == PC_RESET)
      else $error("pc moved in reset");
   chk_irq_clear: assert property (
      @(posedge ref_clk)
      core_rst |=> irq_pend_r == '0)
      else $error("interrupt pending in reset");
   chk_irq_follow: assert property (
      @(posedge ref_clk)
      !core_rst |=> irq_pend_r == $past(irq_src))
      else $error("interrupt source lost");
   chk_pc_next_fetch: assert property (
      @(posedge ref_clk)
      (!core_rst && fetch_ok) |=> pc_r == $past(fetch_addr) + 16'h0001)
      else $error("pc not next address");
   chk_wdt_sticky: assert property (
      @(posedge ref_clk)
      (!core_rst && wdt_en_r) |=> wdt_en_r)
      else $error("watchdog dropped without reset");
   chk_code_read_only: assert property (
      @(posedge ref_clk)
      (!core_rst && code_wr) |=> data_err_r && !data_gnt_r)
      else $error("program space write granted");
   chk_direct_upper: assert property (
      @(posedge ref_clk)
      (!core_rst && data_req && !data_bit && data_space == MMR_S_DATA &&
      !data_indirect && data_addr[7]) |=> data_err_r && !data_gnt_r)
      else $error("direct upper data access granted");
   chk_xbusy_load: assert property (
      @(posedge ref_clk)
      (!core_rst && x_acc) |=> xbusy_cnt_r == 3'(EXTERNAL_DATA_SPACE_CYC_MIN - 1))
      else $error("external access hold not loaded");
   chk_sfr_direct: assert property (
      @(posedge ref_clk)
      (!core_rst && data_req && !data_bit && data_space == MMR_S_SFR &&
      data_addr[7]) |=> data_tgt_r == MMR_T_REG && data_phys_r[15:7] == '0)
      else $error("register space access misrouted");
   chk_bit_sfr_align: assert property (
      @(posedge ref_clk)
      (!core_rst && data_req && data_bit && data_addr[7])
      |=> data_tgt_r == MMR_T_REG && data_phys_r[2:0] == 3'h0)
      else $error("bit access not on register boundary");
   chk_dma_grant: assert property (
      @(posedge ref_clk)
      (!core_rst && dma_req) |=> dma_gnt_r)
      else $error("dma request not granted");
   chk_fetch_none: assert property (
      @(posedge ref_clk)
      !fetch_ok |=> fetch_tgt_r == MMR_T_NONE)
      else $error("target shown without fetch grant");
   chk_unif_follow: assert property (
      @(posedge ref_clk)
      !core_rst |=> unif_r == $past(unified_map_select_bit))
      else $error("map select not followed");
   chk_external_data_space_flash: assert property (
      @(posedge ref_clk)
      (!core_rst && dma_req &&
      dma_addr <= ((FLASH_KB > 32) ? FL_HI_BIG : FL_HI_32K))
      |=> dma_tgt_r == MMR_T_FLASH)
      else $error("flash window miss");
   chk_idata_sram: assert property (
      @(posedge ref_clk)
      (!core_rst && data_req && !data_bit && data_space == MMR_S_DATA &&
      (data_indirect || !data_addr[7])) |=> data_tgt_r == MMR_T_SRAM &&
      data_phys_r[15:8] == IDATA_BASE[15:8] - SRAM_LO[15:8])
      else $error("data space not in top of sram");
endmodule : mmr_top
